// ===== core/ccs_pkg.sv
package ccs_pkg;
	// ************************************************************
	// Register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] CTRL_ADDR = 8'h00;
	localparam logic [7:0] CFG_ADDR = 8'h04;
	localparam logic [7:0] STATUS_ADDR = 8'h08;
	localparam logic [7:0] STRAP_ADDR = 8'h0C;
	// ************************************************************
	// Control register fields (CTRL_ADDR)
	// ************************************************************
	localparam int CTRL_KICK_BIT = 7;
	localparam int CTRL_NOLIMIT_BIT = 2;
	localparam int CTRL_LIMIT500_BIT = 1;
	localparam int CTRL_INHIBIT_BIT = 0;
	// ************************************************************
	// Config register fields (CFG_ADDR)
	// ************************************************************
	localparam int CFG_RESET_BIT = 7;
	localparam int CFG_TERM_EN_BIT = 6;
	localparam int CFG_VREG_LSB = 0;
	localparam int CFG_VREG_W = 6;
	localparam logic [5:0] VREG_DEFAULT = 6'h02;
	localparam logic TERM_EN_DEFAULT = 1'b0;
	// ************************************************************
	// Status register fields (STATUS_ADDR)
	// ************************************************************
	localparam int ST_FAULT_LSB = 0;
	localparam int ST_PHASE_LSB = 4;
	localparam int ST_HOSTMODE_BIT = 8;
	localparam int ST_CHARGING_BIT = 9;
	localparam int ST_HIZ_BIT = 10;
	localparam int ST_LIMIT500_BIT = 11;
	localparam logic [2:0] FAULT_NONE = 3'h0;
	localparam logic [2:0] FAULT_THERMAL = 3'h5;
	localparam logic [2:0] FAULT_TIMER = 3'h6;
	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_HZ = 100_000_000;
	localparam int TICK_HZ = 1000;
	localparam int TICK_DIV = CLK_HZ / TICK_HZ;
	localparam int SHORT_TIMER_S = 32;
	localparam int LONG_TIMER_MIN = 32;
	localparam int SHORT_TICKS = SHORT_TIMER_S * TICK_HZ;
	localparam int LONG_TICKS = LONG_TIMER_MIN * 60 * TICK_HZ;
	localparam int FAULT_PULSE_US = 128;
	localparam int FAULT_PULSE_CYC = FAULT_PULSE_US * (CLK_HZ / 1_000_000);
	localparam int PWM_HZ = 3_000_000;
	localparam int PWM_PERIOD = CLK_HZ / PWM_HZ;
	localparam int DUTY_MAX_PERMIL = 995;
	localparam int DUTY_MAX = (PWM_PERIOD * DUTY_MAX_PERMIL) / 1000;
	// ************************************************************
	// Charge phases
	// ************************************************************
	typedef enum logic [2:0] {
		PH_OFF, PH_SHORT, PH_FAST, PH_REGULATE, PH_DONE, PH_THERMAL, PH_HIZ
	} ccs_phase_e;
endpackage

// ===== core/ccs_charge_cycle_sequencer.sv
// How it works
// - Long timer runs at start; host write stops it
// - Stopped long timer starts the short timer
// - Kick bit restarts short timer, self-clears
// - Short expiry: stop, defaults, long timer, resume
// - Long expiry: charger off, timer fault code
// - Fault latched; status updates only after read
// - Recharge, weak power-on, inhibit toggle, reset start cycle
// - Regulation phase ends at termination current
// - Termination disabled means never terminate
// - Below short threshold use reduced current
// - Input limit 100 or 500 mA, reset 100
// - Control bit disables input limit entirely
// - Weak power-on without host: defaults, OTG limit
// - Otherwise power-on follows control registers
// - High-impedance variant enters hi-Z at weak power-on
// - Defaults: termination off, 3.54 V regulation
// - Thermal trip suspends, freezes timers, resumes
// - Low-side switch synchronous only above 100mA
// - Fixed 3 MHz switching, high side on at most 32 of 33 cycles
// - Inhibit zero enables, one disables charging
// - Parameter reset restores defaults, self-clears
// - Fault gives one fixed low pulse on indicator
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module ccs_charge_cycle_sequencer #(
	parameter int LONG_TICKS_P = ccs_pkg::LONG_TICKS,
	parameter int SHORT_TICKS_P = ccs_pkg::SHORT_TICKS,
	parameter int TICK_DIV_P = ccs_pkg::TICK_DIV,
	parameter bit HIZ_VARIANT = 1'b0
) (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic [31:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [31:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic OTG_PIN,
	input wire logic BAT_BELOW_SHORT,
	input wire logic BAT_BELOW_WEAK,
	input wire logic BAT_BELOW_RECHARGE,
	input wire logic BAT_AT_REGULATION,
	input wire logic CURRENT_AT_TERM,
	input wire logic THERMAL_TRIP,
	input wire logic LOW_SIDE_ABOVE_100MA,
	output logic CHARGE_EN,
	output logic SHORT_CURRENT_MODE,
	output logic FAST_CURRENT_MODE,
	output logic INPUT_LIMIT_500,
	output logic INPUT_LIMIT_OFF,
	output logic [5:0] REGULATION_VOLTAGE,
	output logic HIGH_SIDE_ON,
	output logic LOW_SIDE_ON,
	output logic STAT_O,
	output logic STAT_OE
);
	// ************************************************************
	// Register bus slave
	// ************************************************************
	logic aw_hold_r, w_hold_r;
	logic [7:0] aw_addr_r;
	logic [31:0] w_data_r;
	logic [3:0] w_strb_r;
	logic bvalid_r, rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] bresp_r, rresp_r;
	logic wr_fire, rd_fire, status_read;
	logic [31:0] status_word;
	logic [7:0] ctrl_r, cfg_r;
	logic strap_weak_r, strap_otg_r;

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a == ccs_pkg::CTRL_ADDR) || (a == ccs_pkg::CFG_ADDR)
			|| (a == ccs_pkg::STATUS_ADDR) || (a == ccs_pkg::STRAP_ADDR);
	endfunction

	assign S_AXI_AWREADY = !aw_hold_r && !bvalid_r;
	assign S_AXI_WREADY = !w_hold_r && !bvalid_r;
	assign S_AXI_ARREADY = !rvalid_r;
	assign S_AXI_BVALID = bvalid_r;
	assign S_AXI_BRESP = bresp_r;
	assign S_AXI_RVALID = rvalid_r;
	assign S_AXI_RDATA = rdata_r;
	assign S_AXI_RRESP = rresp_r;
	assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;
	assign rd_fire = S_AXI_ARVALID && S_AXI_ARREADY;
	assign status_read = rd_fire && (S_AXI_ARADDR[7:0] == ccs_pkg::STATUS_ADDR);

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h00000000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_hold_r <= 1'b1;
				aw_addr_r <= S_AXI_AWADDR[7:0];
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_hold_r <= 1'b1;
				w_data_r <= S_AXI_WDATA;
				w_strb_r <= S_AXI_WSTRB;
			end
			if (wr_fire) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				bvalid_r <= 1'b1;
				bresp_r <= addr_ok(aw_addr_r) ? 2'h0 : 2'h2;
			end else if (bvalid_r && S_AXI_BREADY) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= 2'h0;
		end else if (rd_fire) begin
			rvalid_r <= 1'b1;
			rresp_r <= addr_ok(S_AXI_ARADDR[7:0]) ? 2'h0 : 2'h2;
			unique case (S_AXI_ARADDR[7:0])
				ccs_pkg::CTRL_ADDR: rdata_r <= {24'h000000, ctrl_r};
				ccs_pkg::CFG_ADDR: rdata_r <= {24'h000000, cfg_r};
				ccs_pkg::STATUS_ADDR: rdata_r <= status_word;
				ccs_pkg::STRAP_ADDR: rdata_r <= {30'h00000000, strap_otg_r, strap_weak_r};
				default: rdata_r <= 32'h00000000;
			endcase
		end else if (rvalid_r && S_AXI_RREADY) begin
			rvalid_r <= 1'b0;
		end
	end

	// ************************************************************
	// Control and config registers
	// ************************************************************
	logic host_write, ctrl_wr, cfg_wr, boot_defaults, param_defaults;
	logic inhibit_toggle, kick_pending, param_reset_req;
	logic boot_done_r, host_mode_r, otg_limit_mode_r, hiz_r;
	logic short_expire;

	assign host_write = wr_fire && addr_ok(aw_addr_r);
	assign ctrl_wr = wr_fire && (aw_addr_r == ccs_pkg::CTRL_ADDR) && w_strb_r[0];
	assign cfg_wr = wr_fire && (aw_addr_r == ccs_pkg::CFG_ADDR) && w_strb_r[0];
	assign inhibit_toggle = ctrl_wr
		&& (w_data_r[ccs_pkg::CTRL_INHIBIT_BIT] != ctrl_r[ccs_pkg::CTRL_INHIBIT_BIT]);
	assign kick_pending = ctrl_r[ccs_pkg::CTRL_KICK_BIT];
	assign param_reset_req = cfg_r[ccs_pkg::CFG_RESET_BIT];
	assign param_defaults = param_reset_req || short_expire;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			ctrl_r <= 8'h00;
		end else if (boot_defaults) begin
			ctrl_r <= 8'h00;
		end else if (ctrl_wr) begin
			ctrl_r <= w_data_r[7:0];
		end else if (kick_pending) begin
			ctrl_r[ccs_pkg::CTRL_KICK_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST || boot_defaults) begin
			cfg_r <= {1'b0, ccs_pkg::TERM_EN_DEFAULT, ccs_pkg::VREG_DEFAULT};
		end else if (cfg_wr) begin
			cfg_r <= w_data_r[7:0];
		end else if (param_defaults) begin
			cfg_r <= {1'b0, ccs_pkg::TERM_EN_DEFAULT, ccs_pkg::VREG_DEFAULT};
		end
	end

	// ************************************************************
	// Power-on boot sequence
	// ************************************************************
	assign boot_defaults = !boot_done_r && BAT_BELOW_WEAK && !host_mode_r && !HIZ_VARIANT;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			boot_done_r <= 1'b0;
			strap_weak_r <= 1'b0;
			strap_otg_r <= 1'b0;
			otg_limit_mode_r <= 1'b0;
			hiz_r <= 1'b0;
		end else if (!boot_done_r) begin
			boot_done_r <= 1'b1;
			strap_weak_r <= BAT_BELOW_WEAK;
			strap_otg_r <= OTG_PIN;
			otg_limit_mode_r <= BAT_BELOW_WEAK && !HIZ_VARIANT;
			hiz_r <= BAT_BELOW_WEAK && HIZ_VARIANT;
		end else if (host_write) begin
			otg_limit_mode_r <= 1'b0;
			hiz_r <= 1'b0;
		end
	end

	always_comb begin
		if (otg_limit_mode_r) begin
			INPUT_LIMIT_500 = strap_otg_r;
		end else begin
			INPUT_LIMIT_500 = ctrl_r[ccs_pkg::CTRL_LIMIT500_BIT];
		end
		INPUT_LIMIT_OFF = ctrl_r[ccs_pkg::CTRL_NOLIMIT_BIT] && !otg_limit_mode_r;
	end
	assign REGULATION_VOLTAGE = cfg_r[ccs_pkg::CFG_VREG_LSB +: ccs_pkg::CFG_VREG_W];

	// ************************************************************
	// Safety timers
	// ************************************************************
	logic [$clog2(TICK_DIV_P+1)-1:0] div_r;
	logic tick, long_expire, timer_fault_r;
	logic [31:0] long_cnt_r, short_cnt_r;
	logic long_run_r, short_run_r;

	assign tick = (div_r == $bits(div_r)'(TICK_DIV_P - 1)) && !THERMAL_TRIP;
	assign long_expire = long_run_r && tick && (long_cnt_r == 32'(LONG_TICKS_P - 1));
	assign short_expire = short_run_r && tick && (short_cnt_r == 32'(SHORT_TICKS_P - 1));

	always_ff @(posedge CLK) begin
		if (SYS_RST || tick) begin
			div_r <= '0;
		end else if (!THERMAL_TRIP) begin
			div_r <= div_r + 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			long_run_r <= 1'b1;
			short_run_r <= 1'b0;
			long_cnt_r <= 32'h00000000;
			short_cnt_r <= 32'h00000000;
			host_mode_r <= 1'b0;
			timer_fault_r <= 1'b0;
		end else if (timer_fault_r) begin
			long_run_r <= 1'b0;
			short_run_r <= 1'b0;
		end else if (long_expire) begin
			long_run_r <= 1'b0;
			timer_fault_r <= 1'b1;
		end else if (short_expire) begin
			short_run_r <= 1'b0;
			long_run_r <= 1'b1;
			long_cnt_r <= 32'h00000000;
			host_mode_r <= 1'b0;
		end else if (host_write && long_run_r) begin
			long_run_r <= 1'b0;
			short_run_r <= 1'b1;
			short_cnt_r <= 32'h00000000;
			host_mode_r <= 1'b1;
		end else if (kick_pending && short_run_r) begin
			short_cnt_r <= 32'h00000000;
		end else if (tick) begin
			if (long_run_r) begin
				long_cnt_r <= long_cnt_r + 32'h00000001;
			end
			if (short_run_r) begin
				short_cnt_r <= short_cnt_r + 32'h00000001;
			end
		end
	end

	// ************************************************************
	// Charge phase sequencing
	// ************************************************************
	ccs_pkg::ccs_phase_e phase_r;
	logic enabled, term_hit, restart;

	assign enabled = !ctrl_r[ccs_pkg::CTRL_INHIBIT_BIT] && !timer_fault_r && !hiz_r;
	assign term_hit = cfg_r[ccs_pkg::CFG_TERM_EN_BIT] && CURRENT_AT_TERM
		&& !BAT_BELOW_RECHARGE;
	assign restart = inhibit_toggle || param_reset_req || short_expire;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			phase_r <= ccs_pkg::PH_OFF;
		end else if (hiz_r) begin
			phase_r <= ccs_pkg::PH_HIZ;
		end else if (!enabled) begin
			phase_r <= ccs_pkg::PH_OFF;
		end else if (THERMAL_TRIP) begin
			phase_r <= ccs_pkg::PH_THERMAL;
		end else if (restart) begin
			phase_r <= ccs_pkg::PH_OFF;
		end else begin
			unique case (phase_r)
				ccs_pkg::PH_OFF, ccs_pkg::PH_THERMAL, ccs_pkg::PH_HIZ,
				ccs_pkg::PH_SHORT, ccs_pkg::PH_FAST: begin
					if (BAT_BELOW_SHORT) begin
						phase_r <= ccs_pkg::PH_SHORT;
					end else if (BAT_AT_REGULATION) begin
						phase_r <= ccs_pkg::PH_REGULATE;
					end else begin
						phase_r <= ccs_pkg::PH_FAST;
					end
				end
				ccs_pkg::PH_REGULATE: begin
					if (term_hit) begin
						phase_r <= ccs_pkg::PH_DONE;
					end else if (!BAT_AT_REGULATION) begin
						phase_r <= ccs_pkg::PH_FAST;
					end
				end
				ccs_pkg::PH_DONE: begin
					if (BAT_BELOW_RECHARGE) begin
						phase_r <= ccs_pkg::PH_OFF;
					end
				end
			endcase
		end
	end

	logic active;
	assign active = (phase_r == ccs_pkg::PH_SHORT) || (phase_r == ccs_pkg::PH_FAST)
		|| (phase_r == ccs_pkg::PH_REGULATE);
	assign CHARGE_EN = active;
	assign SHORT_CURRENT_MODE = phase_r == ccs_pkg::PH_SHORT;
	assign FAST_CURRENT_MODE = (phase_r == ccs_pkg::PH_FAST) || (phase_r == ccs_pkg::PH_REGULATE);

	// ************************************************************
	// Fault latch with read-gated status
	// ************************************************************
	logic [2:0] fault_now, fault_shown_r;
	logic fault_seen_r;

	always_comb begin
		if (timer_fault_r) begin
			fault_now = ccs_pkg::FAULT_TIMER;
		end else if (THERMAL_TRIP) begin
			fault_now = ccs_pkg::FAULT_THERMAL;
		end else begin
			fault_now = ccs_pkg::FAULT_NONE;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			fault_shown_r <= ccs_pkg::FAULT_NONE;
			fault_seen_r <= 1'b1;
		end else if (status_read) begin
			fault_seen_r <= 1'b1;
		end else if (fault_seen_r && fault_now != fault_shown_r) begin
			fault_shown_r <= fault_now;
			fault_seen_r <= 1'b0;
		end
	end

	assign status_word = {20'h00000, INPUT_LIMIT_500, hiz_r, active, host_mode_r,
		1'b0, phase_r, 1'b0, fault_shown_r};

	// ************************************************************
	// Fault indicator pulse
	// ************************************************************
	logic [$clog2(ccs_pkg::FAULT_PULSE_CYC+1)-1:0] pulse_cnt_r;
	logic fault_prev_r;

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			pulse_cnt_r <= '0;
			fault_prev_r <= 1'b0;
		end else begin
			fault_prev_r <= fault_now != ccs_pkg::FAULT_NONE;
			if ((fault_now != ccs_pkg::FAULT_NONE) && !fault_prev_r) begin
				pulse_cnt_r <= $bits(pulse_cnt_r)'(ccs_pkg::FAULT_PULSE_CYC);
			end else if (pulse_cnt_r != '0) begin
				pulse_cnt_r <= pulse_cnt_r - 1'b1;
			end
		end
	end

	assign STAT_O = 1'b0;
	assign STAT_OE = pulse_cnt_r != '0;

	// ************************************************************
	// Switching controller timing
	// ************************************************************
	logic [$clog2(ccs_pkg::PWM_PERIOD)-1:0] pwm_cnt_r;
	logic hs_r, ls_r;

	always_ff @(posedge CLK) begin
		if (SYS_RST || pwm_cnt_r == $bits(pwm_cnt_r)'(ccs_pkg::PWM_PERIOD - 1)) begin
			pwm_cnt_r <= '0;
		end else begin
			pwm_cnt_r <= pwm_cnt_r + 1'b1;
		end
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST || !active) begin
			hs_r <= 1'b0;
			ls_r <= 1'b0;
		end else begin
			hs_r <= pwm_cnt_r < $bits(pwm_cnt_r)'(ccs_pkg::DUTY_MAX);
			ls_r <= (pwm_cnt_r >= $bits(pwm_cnt_r)'(ccs_pkg::DUTY_MAX))
				&& LOW_SIDE_ABOVE_100MA;
		end
	end

	assign HIGH_SIDE_ON = hs_r;
	assign LOW_SIDE_ON = ls_r;
endmodule
`default_nettype wire

// ===== dv/ccs_bat_model.sv
`timescale 1ns/100ps
`default_nettype none
// ************************************************************
// Battery pack seen through the threshold comparators
// ************************************************************
module ccs_bat_model (
	input wire logic [2:0] lvl,
	input wire logic charge_en,
	output logic below_short,
	output logic below_weak,
	output logic below_recharge,
	output logic at_regulation,
	output logic current_at_term,
	output logic low_side_above_100ma
);
	// Levels: 0 shorted, 1 weak, 2 under recharge, 3 charged, 4 at regulation
	assign below_short = (lvl == 3'h0);
	assign below_weak = (lvl < 3'h2);
	assign below_recharge = (lvl < 3'h3);
	assign at_regulation = (lvl == 3'h4);
	assign current_at_term = (lvl == 3'h4);
	assign low_side_above_100ma = charge_en && (lvl != 3'h4);
endmodule
`default_nettype wire

// ===== dv/ccs_chk.sv
`timescale 1ns/100ps
`default_nettype none
module ccs_chk (
	input wire logic CLK,
	input wire logic SYS_RST,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	input wire logic BAT_BELOW_SHORT,
	input wire logic THERMAL_TRIP,
	input wire logic LOW_SIDE_ABOVE_100MA,
	input wire logic CHARGE_EN,
	input wire logic SHORT_CURRENT_MODE,
	input wire logic INPUT_LIMIT_500,
	input wire logic INPUT_LIMIT_OFF,
	input wire logic [5:0] REGULATION_VOLTAGE,
	input wire logic HIGH_SIDE_ON,
	input wire logic LOW_SIDE_ON,
	input wire logic STAT_OE
);
	localparam int PULSE = ccs_pkg::FAULT_PULSE_CYC;
	int hs_run_r;
	int oe_run_r;
	// ************************************************************
	// Run lengths of the high-side gate and the indicator pulse
	// ************************************************************
	always_ff @(posedge CLK) begin
		if (SYS_RST || !HIGH_SIDE_ON) hs_run_r <= 0;
		else hs_run_r <= hs_run_r + 1;
	end
	always_ff @(posedge CLK) begin
		if (SYS_RST || !STAT_OE) oe_run_r <= 0;
		else oe_run_r <= oe_run_r + 1;
	end
	default clocking dc @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	AST_WR_RESP: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
		|-> ##2 S_AXI_BVALID) else $error("write response missing");
	AST_RD_RESP: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY)
		else $error("read response missing");
	AST_RESET_VALUES: assert property ($fell(SYS_RST) |-> !INPUT_LIMIT_500 && !INPUT_LIMIT_OFF
		&& REGULATION_VOLTAGE == ccs_pkg::VREG_DEFAULT && !CHARGE_EN && !STAT_OE)
		else $error("reset values wrong");
	AST_THERMAL_OFF: assert property (THERMAL_TRIP[*3] |-> !CHARGE_EN && !HIGH_SIDE_ON && !LOW_SIDE_ON)
		else $error("charging during thermal trip");
	AST_SHORT_CURRENT: assert property (BAT_BELOW_SHORT[*3] ##0 CHARGE_EN |-> SHORT_CURRENT_MODE)
		else $error("full current into shorted cell");
	AST_LOW_SIDE_OFF: assert property (!LOW_SIDE_ABOVE_100MA[*2] |-> !LOW_SIDE_ON)
		else $error("low-side on at low current");
	AST_DUTY_LIMIT: assert property (HIGH_SIDE_ON |-> hs_run_r < ccs_pkg::DUTY_MAX)
		else $error("high-side on too long");
	AST_STAT_PULSE: assert property ($fell(STAT_OE) |-> oe_run_r == PULSE)
		else $error("indicator pulse length wrong");
endmodule
bind ccs_charge_cycle_sequencer ccs_chk chk_i (.CLK(CLK), .SYS_RST(SYS_RST),
	.S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
	.S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_ARVALID(S_AXI_ARVALID),
	.S_AXI_ARREADY(S_AXI_ARREADY), .S_AXI_RVALID(S_AXI_RVALID), .BAT_BELOW_SHORT(BAT_BELOW_SHORT),
	.THERMAL_TRIP(THERMAL_TRIP), .LOW_SIDE_ABOVE_100MA(LOW_SIDE_ABOVE_100MA), .CHARGE_EN(CHARGE_EN),
	.SHORT_CURRENT_MODE(SHORT_CURRENT_MODE), .INPUT_LIMIT_500(INPUT_LIMIT_500),
	.INPUT_LIMIT_OFF(INPUT_LIMIT_OFF), .REGULATION_VOLTAGE(REGULATION_VOLTAGE),
	.HIGH_SIDE_ON(HIGH_SIDE_ON), .LOW_SIDE_ON(LOW_SIDE_ON), .STAT_OE(STAT_OE));
`default_nettype wire

// ===== dv/ccs_charge_cycle_sequencer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ccs_charge_cycle_sequencer_tb;
	localparam logic [31:0] A_CTRL = {24'h00, ccs_pkg::CTRL_ADDR};
	localparam logic [31:0] A_CFG = {24'h00, ccs_pkg::CFG_ADDR};
	localparam logic [31:0] A_ST = {24'h00, ccs_pkg::STATUS_ADDR};
	localparam logic [31:0] A_STRAP = {24'h00, ccs_pkg::STRAP_ADDR};
	localparam logic [31:0] A_BAD = 32'h00000010;
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready, otg, trip;
	logic awready, wready, bvalid, arready, rvalid, chg, shm, fam, l500, loff, hs, ls, so, soe;
	logic b_sh, b_wk, b_rc, b_rg, b_tm, ls100;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [1:0] bresp, rresp;
	logic [5:0] vreg;
	logic [2:0] lvl;
	int bad_count, n_compared;
	ccs_charge_cycle_sequencer #(.LONG_TICKS_P(40), .SHORT_TICKS_P(25), .TICK_DIV_P(4),
		.HIZ_VARIANT(1'b0)) uut (.CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awaddr),
		.S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .OTG_PIN(otg), .BAT_BELOW_SHORT(b_sh), .BAT_BELOW_WEAK(b_wk),
		.BAT_BELOW_RECHARGE(b_rc), .BAT_AT_REGULATION(b_rg), .CURRENT_AT_TERM(b_tm),
		.THERMAL_TRIP(trip), .LOW_SIDE_ABOVE_100MA(ls100), .CHARGE_EN(chg), .SHORT_CURRENT_MODE(shm),
		.FAST_CURRENT_MODE(fam), .INPUT_LIMIT_500(l500), .INPUT_LIMIT_OFF(loff),
		.REGULATION_VOLTAGE(vreg), .HIGH_SIDE_ON(hs), .LOW_SIDE_ON(ls), .STAT_O(so), .STAT_OE(soe));
	ccs_bat_model bat (.lvl(lvl), .charge_en(chg), .below_short(b_sh), .below_weak(b_wk),
		.below_recharge(b_rc), .at_regulation(b_rg), .current_at_term(b_tm),
		.low_side_above_100ma(ls100));
	// ************************************************************
	// Compare, bus and wait tasks
	// ************************************************************
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic cmp_bit(input logic g, input logic e);
		cmp({31'h0, g}, {31'h0, e});
	endtask
	task automatic wt(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [1:0] r;
		r = 2'bxx;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) begin
				r = bresp;
				break;
			end
		end
		bready <= 1'b0;
		cmp({30'h0, r}, {30'h0, er});
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		logic [31:0] d;
		logic [1:0] r;
		d = 'x;
		r = 2'bxx;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				break;
			end
		end
		rready <= 1'b0;
		cmp(d & m, e);
		cmp({30'h0, r}, {30'h0, er});
	endtask
	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (40000) @(posedge clk);
		bad_count++;
		test_done();
	end
	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, trip} = '0;
		{awaddr, wdata, araddr} = '0;
		{bad_count, n_compared} = '0;
		otg = 1'b1;
		lvl = 3'h0;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wt(3);
		cmp_bit(chg, 1'b1);
		cmp_bit(l500, 1'b1);
		cmp_bit(shm, 1'b1);
		@(posedge clk);
		lvl <= 3'h1;
		wt(5);
		cmp_bit(fam, 1'b1);
		rd(A_STRAP, 32'h3, 32'h3, 2'h0);
		rd(A_CTRL, 32'hFF, 32'h0, 2'h0);
		rd(A_CFG, 32'hFF, 32'h02, 2'h0);
		rd(A_BAD, 32'hFFFFFFFF, 32'h0, 2'h2);
		$display("boot test done");
		wr(A_CFG, 32'h45, 2'h0);
		wt(3);
		cmp_bit(l500, 1'b0);
		cmp({26'h0, vreg}, 32'h5);
		repeat (4) begin
			wr(A_CTRL, 32'h80, 2'h0);
			wt(40);
		end
		rd(A_ST, 32'h7, {29'h0, ccs_pkg::FAULT_NONE}, 2'h0);
		rd(A_CTRL, 32'h80, 32'h0, 2'h0);
		rd(A_CFG, 32'hFF, 32'h45, 2'h0);
		wr(A_BAD, 32'h0, 2'h2);
		wt(130);
		rd(A_CFG, 32'hFF, 32'h02, 2'h0);
		cmp_bit(chg, 1'b1);
		wt(200);
		rd(A_ST, 32'h7, {29'h0, ccs_pkg::FAULT_TIMER}, 2'h0);
		cmp_bit(chg, 1'b0);
		cmp_bit(soe, 1'b1);
		cmp_bit(so, 1'b0);
		wr(A_CTRL, 32'h80, 2'h0);
		wt(5);
		rd(A_ST, 32'h7, {29'h0, ccs_pkg::FAULT_TIMER}, 2'h0);
		cmp_bit(chg, 1'b0);
		wt(13000);
		cmp_bit(soe, 1'b0);
		$display("timer test done");
		@(posedge clk);
		rst <= 1'b1;
		lvl <= 3'h3;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		wt(3);
		cmp_bit(l500, 1'b0);
		cmp_bit(chg, 1'b1);
		wr(A_CFG, 32'h42, 2'h0);
		@(posedge clk);
		lvl <= 3'h4;
		wt(5);
		cmp_bit(chg, 1'b0);
		rd(A_ST, 32'h70, {25'h0, ccs_pkg::PH_DONE, 4'h0}, 2'h0);
		@(posedge clk);
		lvl <= 3'h2;
		wt(5);
		cmp_bit(chg, 1'b1);
		wr(A_CFG, 32'h02, 2'h0);
		@(posedge clk);
		lvl <= 3'h4;
		wt(8);
		cmp_bit(chg, 1'b1);
		wr(A_CTRL, 32'h81, 2'h0);
		wt(3);
		cmp_bit(chg, 1'b0);
		wr(A_CTRL, 32'h80, 2'h0);
		wt(3);
		cmp_bit(chg, 1'b1);
		wr(A_CTRL, 32'h84, 2'h0);
		wt(2);
		cmp_bit(loff, 1'b1);
		wr(A_CTRL, 32'h82, 2'h0);
		wt(2);
		cmp_bit(l500, 1'b1);
		wr(A_CFG, 32'h85, 2'h0);
		wt(3);
		rd(A_CFG, 32'hFF, 32'h02, 2'h0);
		wr(A_CFG, 32'h07, 2'h0);
		wr(A_CTRL, 32'h80, 2'h0);
		@(posedge clk);
		trip <= 1'b1;
		wt(150);
		cmp_bit(chg, 1'b0);
		rd(A_ST, 32'h70, {25'h0, ccs_pkg::PH_THERMAL, 4'h0}, 2'h0);
		@(posedge clk);
		trip <= 1'b0;
		wt(5);
		cmp_bit(chg, 1'b1);
		rd(A_CFG, 32'hFF, 32'h07, 2'h0);
		$display("host test done");
		test_done();
	end
endmodule
`default_nettype wire
